// File: pkg/cog_pkg.sv
// Purpose: shared constants and types of the clock output gating block
// Assumes: single pclk domain at 20 MHz, APB register access
// Notes:   output groups travel as one packed struct, thirteen lanes wide
package cog_pkg;

    // ------------------------------------------------------------------
    // clocking and timing
    // ------------------------------------------------------------------
    localparam int unsigned PCLK_MHZ        = 20;
    localparam int unsigned PT_LOSS_NS      = 1000;  // no edge for this long means no platform clock
    localparam int unsigned PT_LOSS_CYC     = (PT_LOSS_NS * PCLK_MHZ) / 1000;
    localparam int unsigned PT_CNT_W        = 8;
    localparam logic [PT_CNT_W-1:0] PT_LOSS_MAX = PT_LOSS_CYC[PT_CNT_W-1:0];
    localparam logic [PT_CNT_W-1:0] PT_CNT_ZERO = 8'h00;
    localparam logic [PT_CNT_W-1:0] PT_CNT_ONE  = 8'h01;

    // ------------------------------------------------------------------
    // output lanes
    // ------------------------------------------------------------------
    localparam int unsigned NUM_OUTS = 13;

    typedef struct packed {
        logic       twenty_five_mhz_output;     // lane 12
        logic [5:0] muxable_clock_outputs;      // lanes 11..6
        logic [5:0] hundred_mhz_outputs;        // lanes 5..0
    } cog_outs_s;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_OUT_ENABLE = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h004;
    localparam logic [12:0] OUT_ENABLE_RST  = 13'h1FFF;  // every output enabled after power-up
    localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

    // status bit positions
    localparam int unsigned ST_PWR_GOOD   = 0;
    localparam int unsigned ST_PT_PRESENT = 1;
    localparam int unsigned ST_SRC_PT     = 2;
    localparam int unsigned ST_RUN_LSB    = 8;

endpackage : cog_pkg

// File: rtl/cog_sync3.sv
// Purpose: three flip-flop pin synchroniser with agreement filter
// Assumes: d is asynchronous to clk
// Notes:   q moves only once the second and third stages agree
`timescale 1ns/1ns
`default_nettype none
module cog_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic d,
    output var  logic q
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic q_q;

    // ------------------------------------------------------------------
    // synchroniser chain, first stage read only by the second
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else if (ce) begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a level once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_q <= RST_VAL;
        end else if (ce && (s2_q == s3_q)) begin
            q_q <= s3_q;
        end
    end

    assign q = q_q;

endmodule // cog_sync3
`default_nettype wire

// File: rtl/cog_gate.sv
// Purpose: source select and output gating of a multi-output reference clock generator
// Assumes: src_phase comes from synthesiser logic on pclk; pins pass through cog_sync3
// Notes:   enable register is reached over APB; writes need power good
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - lock local 25 MHz to platform clock
// - no platform clock: use local crystal
// - thirteen enable bits, one per output
// - enable bits active high, reset to one
// - 100 MHz outputs need power good and enable
// - mux and 25 MHz outputs likewise gated
// - disabled pair drives both lines low
// - open-drain missing flag when platform clock absent
// - enable writes only while power good high
module cog_gate
    import cog_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                clk_en,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    // pins
    input  wire logic                power_good_in,
    input  wire logic                platform_time_clk_in,
    input  wire logic                crystal_or_ref_in,
    output var  logic                platform_time_missing_n_o,
    output var  logic                platform_time_missing_n_oe,
    // local reference
    output var  logic                ref_from_platform,
    output var  logic                local_ref_clk,
    // clock lanes
    input  wire cog_pkg::cog_outs_s  src_phase,
    output var  cog_pkg::cog_outs_s  out_true,
    output var  cog_pkg::cog_outs_s  out_comp
);

    import cog_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic                pg_s;
    logic                pt_s;
    logic                xtal_s;
    logic                pt_prev_q;
    logic [PT_CNT_W-1:0] pt_cnt_q;
    logic                pt_present_q;
    logic                local_ref_q;
    logic [12:0]         en_q;
    logic [12:0]         gate_q;
    logic [12:0]         gate_d;
    logic [12:0]         permit;
    logic [12:0]         phase;
    logic [12:0]         true_q;
    logic [12:0]         comp_q;
    logic [31:0]         prdata_q;
    logic                addr_ok;
    logic                wr_access;
    logic                rd_setup;

    // lane gate: a lane runs only with power good and its enable bit
    function automatic logic [12:0] lane_permit(input logic pg, input logic [12:0] en);
        lane_permit = pg ? en : 13'h0000;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    cog_sync3 #(.RST_VAL(1'b0)) u_sync_pg (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (clk_en),
        .d     (power_good_in),
        .q     (pg_s)
    );

    cog_sync3 #(.RST_VAL(1'b0)) u_sync_pt (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (clk_en),
        .d     (platform_time_clk_in),
        .q     (pt_s)
    );

    cog_sync3 #(.RST_VAL(1'b0)) u_sync_xtal (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (clk_en),
        .d     (crystal_or_ref_in),
        .q     (xtal_s)
    );

    // ------------------------------------------------------------------
    // platform clock activity detector
    // ------------------------------------------------------------------
    // any edge restarts the loss timer; timeout clears presence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pt_prev_q    <= 1'b0;
            pt_cnt_q     <= PT_CNT_ZERO;
            pt_present_q <= 1'b0;
        end else if (clk_en) begin
            pt_prev_q <= pt_s;
            if (pt_s != pt_prev_q) begin
                pt_cnt_q     <= PT_CNT_ZERO;
                pt_present_q <= 1'b1;
            end else if (pt_cnt_q >= PT_LOSS_MAX - PT_CNT_ONE) begin
                pt_present_q <= 1'b0;
            end else begin
                pt_cnt_q <= pt_cnt_q + PT_CNT_ONE;
            end
        end
    end

    // open drain: pull low while no platform clock is seen
    assign platform_time_missing_n_o  = 1'b0;
    assign platform_time_missing_n_oe = ~pt_present_q;

    // ------------------------------------------------------------------
    // local 25 MHz source selection
    // ------------------------------------------------------------------
    // follow platform clock when present, else the crystal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            local_ref_q <= 1'b0;
        end else if (clk_en) begin
            if (pt_present_q) begin
                local_ref_q <= pt_s;
            end else begin
                local_ref_q <= xtal_s;
            end
        end
    end

    assign ref_from_platform = pt_present_q;
    assign local_ref_clk     = local_ref_q;

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    assign addr_ok   = (paddr == ADDR_OUT_ENABLE) || (paddr == ADDR_STATUS);
    assign wr_access = psel && penable && pwrite && (paddr == ADDR_OUT_ENABLE) && pg_s;
    assign rd_setup  = psel && !penable && !pwrite;
    assign pready    = 1'b1;
    // unmapped address, or enable write without power good, errors
    assign pslverr   = psel && penable &&
                       (!addr_ok || (pwrite && (paddr == ADDR_OUT_ENABLE) && !pg_s));

    // enable register, byte lanes over the low thirteen bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= OUT_ENABLE_RST;
        end else if (clk_en && wr_access) begin
            if (pstrb[0]) begin
                en_q[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                en_q[12:8] <= pwdata[12:8];
            end
        end
    end

    // read data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RDATA_ZERO;
        end else if (clk_en && rd_setup) begin
            prdata_q <= RDATA_ZERO;
            if (paddr == ADDR_OUT_ENABLE) begin
                prdata_q[12:0] <= en_q;
            end else if (paddr == ADDR_STATUS) begin
                prdata_q[ST_PWR_GOOD]               <= pg_s;
                prdata_q[ST_PT_PRESENT]             <= pt_present_q;
                prdata_q[ST_SRC_PT]                 <= pt_present_q;
                prdata_q[ST_RUN_LSB +: NUM_OUTS]    <= gate_q;
            end
        end
    end

    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // output gating
    // ------------------------------------------------------------------
    assign phase  = src_phase;
    assign permit = lane_permit(pg_s, en_q);

    // a lane changes state only while its source is low
    always_comb begin
        gate_d = gate_q;
        for (int i = 0; i < NUM_OUTS; i++) begin
            if (!phase[i]) begin
                gate_d[i] = permit[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q <= 13'h0000;
        end else if (clk_en) begin
            gate_q <= gate_d;
        end
    end

    // disabled pair: both lines low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            true_q <= 13'h0000;
            comp_q <= 13'h0000;
        end else if (clk_en) begin
            true_q <= gate_d & phase;
            comp_q <= gate_d & ~phase;
        end
    end

    assign out_true = true_q;
    assign out_comp = comp_q;

endmodule // cog_gate
`default_nettype wire

// File: dv/cog_gate_assertions.sv
// Purpose: port-level checks of cog_gate
// Assumes: clk_en high; partner toggles lanes every two cycles
// Notes:   bound from tb
`timescale 1ns/1ns
`default_nettype none
module cog_gate_assertions
    import cog_pkg::*;
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic               pslverr,
    input wire logic               power_good_in,
    input wire logic               platform_time_clk_in,
    input wire logic               platform_time_missing_n_o,
    input wire logic               platform_time_missing_n_oe,
    input wire logic               ref_from_platform,
    input wire logic               local_ref_clk,
    input wire logic               crystal_or_ref_in,
    input wire cog_pkg::cog_outs_s src_phase,
    input wire cog_pkg::cog_outs_s out_true,
    input wire cog_pkg::cog_outs_s out_comp
);
    logic [7:0] idle_q;
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    logic       pt_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // run lengths of quiet platform clock and of each power good level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pt_q   <= 1'b0;
            idle_q <= 8'h00;
            lo_q   <= 8'h00;
            hi_q   <= 8'h00;
        end else begin
            pt_q   <= platform_time_clk_in;
            idle_q <= (platform_time_clk_in != pt_q) ? 8'h00 : idle_q + {7'h00, idle_q != 8'hFF};
            lo_q   <= power_good_in ? 8'h00 : lo_q + {7'h00, lo_q != 8'hFF};
            hi_q   <= power_good_in ? hi_q + {7'h00, hi_q != 8'hFF} : 8'h00;
        end
    end
    property p_pair_low; (out_true & out_comp) == 13'h0000; endproperty
    property p_true_ph; (out_true & ~$past(src_phase)) == 13'h0000; endproperty
    property p_comp_ph; (out_comp & $past(src_phase)) == 13'h0000; endproperty
    property p_pg_off; lo_q >= 8'h0A |-> (out_true | out_comp) == 13'h0000; endproperty
    property p_no_runt; (out_true & ~$past(out_true) & ~$past(out_comp)) == 13'h0000; endproperty
    property p_lost; idle_q >= 8'h1E |-> platform_time_missing_n_oe && !ref_from_platform; endproperty
    property p_found;
        (idle_q < 8'h03)[*8] |-> ##4 (!platform_time_missing_n_oe && ref_from_platform);
    endproperty
    property p_od_low; platform_time_missing_n_o == 1'b0; endproperty
    property p_wr_nopg;
        psel && penable && pwrite && paddr == ADDR_OUT_ENABLE && lo_q >= 8'h06 |-> pslverr;
    endproperty
    property p_wr_pg; psel && penable && paddr == ADDR_OUT_ENABLE && hi_q >= 8'h06 |-> !pslverr; endproperty
    // local reference trails its selected pin by the synchroniser and select stages
    property p_ref_xtal; $past(!ref_from_platform) |-> local_ref_clk == $past(crystal_or_ref_in, 5); endproperty
    property p_ref_pt; $past(ref_from_platform) |-> local_ref_clk == $past(platform_time_clk_in, 5); endproperty
    a_pair_low: assert property (p_pair_low)
        else $error("both lines of a pair high");
    a_true_ph: assert property (p_true_ph)
        else $error("true line high without source phase");
    a_comp_ph: assert property (p_comp_ph)
        else $error("complement high with source phase");
    a_pg_off: assert property (p_pg_off)
        else $error("output runs without power good");
    a_no_runt: assert property (p_no_runt)
        else $error("true line started outside a low phase");
    a_lost: assert property (p_lost)
        else $error("quiet platform clock not flagged");
    a_found: assert property (p_found)
        else $error("running platform clock not followed");
    a_od_low: assert property (p_od_low)
        else $error("open drain drives high");
    a_wr_nopg: assert property (p_wr_nopg)
        else $error("enable write accepted without power good");
    a_wr_pg: assert property (p_wr_pg)
        else $error("enable access refused with power good");
    a_ref_xtal: assert property (p_ref_xtal)
        else $error("local reference not taken from crystal");
    a_ref_pt: assert property (p_ref_pt)
        else $error("local reference not taken from platform clock");
    c_lost: cover property (idle_q == 8'h1E);
    c_err: cover property (psel && penable && pslverr);
    c_run: cover property (out_true != 13'h0000);
endmodule // cog_gate_assertions
`default_nettype wire

// File: dv/cog_load_model.sv
// Purpose: far side: lane phase source and platform clock
// Assumes: one pclk domain
// Notes:   stopped platform clock rests low
`timescale 1ns/1ns
`default_nettype none
module cog_load_model
    import cog_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               pt_run,
    output var  cog_pkg::cog_outs_s src_phase,
    output var  logic               platform_time_clk_in,
    output var  logic               crystal_or_ref_in
);
    logic [3:0] cnt_q;
    logic [1:0] div_q;
    // free counter and three-cycle platform half period; a stop finishes the high half
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            div_q <= 2'h0;
            platform_time_clk_in <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            div_q <= (div_q == 2'h2 || (!pt_run && !platform_time_clk_in)) ? 2'h0 : div_q + 2'h1;
            if ((pt_run || platform_time_clk_in) && div_q == 2'h2) begin
                platform_time_clk_in <= ~platform_time_clk_in;
            end
        end
    end
    // odd lanes run in anti-phase to even ones; crystal slow enough for the pin filter
    always_comb begin
        src_phase = cnt_q[1] ? 13'h0AAA : 13'h1555;
        crystal_or_ref_in = cnt_q[2];
    end
endmodule // cog_load_model
`default_nettype wire

// File: dv/tb.sv
// Purpose: directed bench of cog_gate over APB
// Assumes: clk_en tied high
// Notes:   expectations from package constants
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin mismatches++; $display("BAD %0t %s", $time, m); end end
module tb;
    import cog_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, power_good_in = 1'b0, pt_run = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
    logic [3:0]  pstrb = 4'h3;
    logic        pready, pslverr, pt_clk, xtal, miss_o, miss_oe, ref_pf, ref_clk;
    cog_outs_s   phase, o_t, o_c;
    int          mismatches = 0, check_count = 0;
    always #25 pclk = ~pclk;
    cog_load_model i_cog_load_model (.pclk(pclk), .presetn(presetn), .pt_run(pt_run), .src_phase(phase),
        .platform_time_clk_in(pt_clk), .crystal_or_ref_in(xtal));
    cog_gate i_cog_gate (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_good_in(power_good_in), .platform_time_clk_in(pt_clk),
        .crystal_or_ref_in(xtal), .platform_time_missing_n_o(miss_o), .platform_time_missing_n_oe(miss_oe),
        .ref_from_platform(ref_pf), .local_ref_clk(ref_clk), .src_phase(phase), .out_true(o_t), .out_comp(o_c));
    // one apb transfer: setup, access until pready, then release
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        `CHK(pready, 1'b1, "no ready")
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, ADDR_OUT_ENABLE, 32'h0, 4'h3);
        `CHK(rd[12:0], OUT_ENABLE_RST, "enable reset")
        `CHK(o_t | o_c, 13'h0000, "runs without power good")
        xfer(1'b1, ADDR_OUT_ENABLE, 32'h0, 4'h3);
        `CHK(er, 1'b1, "write without power good")
        xfer(1'b0, ADDR_OUT_ENABLE, 32'h0, 4'h3);
        `CHK(rd[12:0], 13'h1FFF, "enable changed")
        `CHK({miss_o, miss_oe, ref_pf}, 3'b010, "platform clock absent")
        $display("test defaults done");
        @(posedge pclk);
        power_good_in <= 1'b1;
        settle(12);
        `CHK(o_t | o_c, 13'h1FFF, "all lanes")
        for (int i = 0; i < 13; i++) begin
            xfer(1'b1, ADDR_OUT_ENABLE, 32'h1 << i, 4'h3);
            settle(5);
            `CHK(o_t | o_c, 13'h0001 << i, "single lane")
            xfer(1'b0, ADDR_STATUS, 32'h0, 4'h3);
            `CHK(rd[20:8], 13'h0001 << i, "status lanes")
        end
        xfer(1'b1, ADDR_OUT_ENABLE, 32'hFFFF_FFFF, 4'h1);
        xfer(1'b0, ADDR_OUT_ENABLE, 32'h0, 4'h3);
        `CHK(rd[12:0], 13'h10FF, "low byte strobe")
        xfer(1'b1, ADDR_OUT_ENABLE, 32'hFFFF_FFFF, 4'h2);
        xfer(1'b0, ADDR_OUT_ENABLE, 32'h0, 4'h3);
        `CHK(rd[12:0], 13'h1FFF, "high byte strobe")
        $display("test lanes done");
        @(posedge pclk);
        power_good_in <= 1'b0;
        settle(12);
        `CHK(o_t | o_c, 13'h0000, "power good dropped")
        xfer(1'b1, ADDR_OUT_ENABLE, 32'h0, 4'h3);
        `CHK(er, 1'b1, "write after power good dropped")
        xfer(1'b0, 12'h008, 32'h0, 4'h3);
        `CHK({er, rd}, {1'b1, RDATA_ZERO}, "unmapped read")
        xfer(1'b1, ADDR_STATUS, 32'h0, 4'h3);
        `CHK(er, 1'b0, "status write")
        power_good_in <= 1'b1;
        pt_run <= 1'b1;
        settle(16);
        `CHK({miss_oe, ref_pf, o_t | o_c}, {2'b01, 13'h1FFF}, "platform clock found")
        @(posedge pclk);
        pt_run <= 1'b0;
        settle(30);
        `CHK({miss_o, miss_oe, ref_pf}, 3'b010, "platform clock lost")
        $display("test platform done");
        print_verdict;
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        print_verdict;
    end
endmodule // tb
bind cog_gate cog_gate_assertions i_cog_gate_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr), .power_good_in(power_good_in),
    .platform_time_clk_in(platform_time_clk_in), .platform_time_missing_n_o(platform_time_missing_n_o),
    .platform_time_missing_n_oe(platform_time_missing_n_oe), .ref_from_platform(ref_from_platform),
    .local_ref_clk(local_ref_clk), .crystal_or_ref_in(crystal_or_ref_in),
    .src_phase(src_phase), .out_true(out_true), .out_comp(out_comp));
`default_nettype wire
